// ==== rtl/sfr_core.sv ====
// Parameter table reader and reset/status instruction engine
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module sfr_core
  import sfr_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire logic                      ce,
  input  wire logic [sfr_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output var  logic [31:0]               avs_readdata,
  output var  logic                      avs_waitrequest,
  input  wire logic                      hw_reset_n_pin,
  input  wire logic [7:0]                nv_sr1_image,
  output var  logic [7:0]                sr1_out,
  output var  logic [1:0]                io_width_out,
  output var  logic                      dev_reset_out
);
  import sfr_pkg::*;

  sfr_core_if lk ();

  sfr_table_rom u_rom (
    .lk (lk)
  );

  sfr_pin_sync u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .ce      (ce),
    .ps      (lk)
  );

  // Bus handshake state
  sfr_bus_t    bus_q;
  sfr_bus_t    bus_d;
  logic        wait_q;
  logic        wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Device state
  logic [7:0]  ptr_q;
  logic [7:0]  ptr_d;
  logic [1:0]  width_q;
  logic [1:0]  width_d;
  logic        cqr_q;
  logic        cqr_d;
  logic        arm_q;
  logic        arm_d;
  logic        wel_q;
  logic        wel_d;
  logic        vwe_q;
  logic        vwe_d;
  logic        vact_q;
  logic        vact_d;
  logic [7:0]  nv_q;
  logic [7:0]  nv_d;
  logic [7:0]  sr1_q;
  logic [7:0]  sr1_d;
  logic        rej_q;
  logic        rej_d;
  logic [7:0]  rcnt_q;
  logic [7:0]  rcnt_d;
  logic        rpulse_q;

  // Address decode
  wire sel_addr;
  wire sel_data;
  wire sel_cmd;
  wire sel_mode;
  wire sel_stat;
  wire req;
  wire fire;
  wire wr_fire;
  wire rd_fire;

  assign sel_addr = (avs_address == REG_TBL_ADDR);
  assign sel_data = (avs_address == REG_TBL_DATA);
  assign sel_cmd  = (avs_address == REG_CMD);
  assign sel_mode = (avs_address == REG_MODE);
  assign sel_stat = (avs_address == REG_STAT);
  assign req      = avs_read || avs_write;
  assign fire     = (bus_q == BUS_ACK) && req;
  assign wr_fire  = fire && avs_write;
  assign rd_fire  = fire && avs_read;

  // Write data with disabled lanes forced low
  wire [31:0] lane_mask;
  wire [31:0] wdm;

  assign lane_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdm       = avs_writedata & lane_mask;

  // Instruction fields
  wire [7:0] cmd_opc;
  wire [1:0] cmd_wid;
  wire [7:0] cmd_dat;
  wire       cmd_go;

  assign cmd_opc = wdm[CMD_OPC_LSB +: 8];
  assign cmd_wid = wdm[CMD_WID_LSB +: 2];
  assign cmd_dat = wdm[CMD_DAT_LSB +: 8];
  assign cmd_go  = wr_fire && sel_cmd && avs_byteenable[0];

  // Instruction acceptance
  wire wid_ok;
  wire cqr_exit;
  wire ins_ok;
  wire ins_rej;

  assign wid_ok   = (cmd_wid == width_q); // [R5]
  // Continuous quad read swallows everything except its exit code
  assign cqr_exit = cmd_go && cqr_q && (cmd_opc == OPC_CQR_X)
                    && (cmd_wid == WID_4); // [R6]
  assign ins_ok   = cmd_go && wid_ok && !cqr_q; // [R6]
  assign ins_rej  = cmd_go && !ins_ok && !cqr_exit;

  // Decoded instructions
  wire is_rst_en;
  wire is_rst;
  wire is_wren;
  wire is_vwren;
  wire is_wrsr;

  assign is_rst_en = ins_ok && (cmd_opc == OPC_RST_EN);
  assign is_rst    = ins_ok && (cmd_opc == OPC_RST);
  assign is_wren   = ins_ok && (cmd_opc == OPC_WREN);
  assign is_vwren  = ins_ok && (cmd_opc == OPC_VWREN);
  assign is_wrsr   = ins_ok && (cmd_opc == OPC_WRSR);

  // Reset pair and hardware pin
  wire sw_reset;
  wire hw_reset;
  wire do_reset;

  assign sw_reset = is_rst && arm_q; // [R4]
  assign hw_reset = !lk.pin_sync_n;
  assign do_reset = sw_reset || hw_reset;

  // Status writes by path
  wire wr_vol;
  wire wr_nv;
  wire wr_refused;

  assign wr_vol     = is_wrsr && vwe_q; // [R9]
  assign wr_nv      = is_wrsr && !vwe_q && wel_q; // [R8]
  assign wr_refused = is_wrsr && !vwe_q && !wel_q; // [R8]

  // Status register view
  wire [31:0] stat_word;

  // Refusal flag at bit 28, low nibble of the reset count below it
  assign stat_word = {3'h0, rej_q, rcnt_q[3:0], lk.pin_sync_n, cqr_q,
                      width_q, arm_q, vact_q, vwe_q, wel_q, nv_q, sr1_q};

  // Read selection
  wire [31:0] rd_mux;

  assign rd_mux = sel_addr ? {24'h0, ptr_q} :
                  sel_data ? {24'h0, lk.tbl_byte} :
                  sel_mode ? {29'h0, cqr_q, width_q} :
                  sel_stat ? stat_word :
                  32'h0;

  assign lk.tbl_addr  = ptr_q;
  assign lk.pin_raw_n = hw_reset_n_pin;

  // Bus handshake: waitrequest drops for one cycle per request
  always_comb begin
    bus_d   = bus_q;
    wait_d  = wait_q;
    rdata_d = rdata_q;
    case (bus_q)
      BUS_IDLE: begin
        if (req) begin
          bus_d   = BUS_ACK;
          wait_d  = 1'b0;
          rdata_d = avs_read ? rd_mux : 32'h0;
        end
      end
      BUS_ACK: begin
        bus_d  = BUS_IDLE;
        wait_d = 1'b1;
      end
      default: begin
        bus_d  = BUS_IDLE;
        wait_d = 1'b1;
      end
    endcase
  end

  // Table pointer advances on each data read
  always_comb begin
    ptr_d = ptr_q;
    if (wr_fire && sel_addr && avs_byteenable[0]) begin
      ptr_d = wdm[7:0];
    end else if (rd_fire && sel_data) begin
      ptr_d = ptr_q + 8'h01; // [R15]
    end
  end

  // Mode, reset arming and enables
  always_comb begin
    width_d = width_q;
    cqr_d   = cqr_q;
    arm_d   = arm_q;
    wel_d   = wel_q;
    vwe_d   = vwe_q;
    if (wr_fire && sel_mode && avs_byteenable[0]) begin
      width_d = wdm[MODE_WID_LSB +: 2];
      cqr_d   = wdm[MODE_CQR_BIT];
    end
    if (cqr_exit) begin
      cqr_d = 1'b0;
    end
    if (ins_ok) begin
      // Any other accepted instruction breaks the pair
      arm_d = is_rst_en; // [R4]
      vwe_d = is_vwren; // [R9]
      if (is_wren) begin
        wel_d = 1'b1; // [R8]
      end else if (wr_nv) begin
        wel_d = 1'b0;
      end
    end
    if (do_reset) begin
      width_d = WID_RST;
      cqr_d   = 1'b0;
      arm_d   = 1'b0;
      wel_d   = 1'b0;
      vwe_d   = 1'b0;
    end
  end

  // Status register 1 copies
  always_comb begin
    nv_d   = nv_q;
    sr1_d  = sr1_q;
    vact_d = vact_q;
    if (wr_vol) begin
      sr1_d  = cmd_dat; // [R9]
      vact_d = 1'b1;
    end else if (wr_nv) begin
      nv_d = cmd_dat; // [R8]
      if (!vact_q) begin
        sr1_d = cmd_dat;
      end
    end
  end

  // Sticky refusal flag, set wins over a software clear
  always_comb begin
    rej_d = rej_q;
    if (wr_fire && sel_stat && avs_writedata[ST_REJ_BIT]
        && avs_byteenable[3]) begin
      rej_d = 1'b0;
    end
    if (ins_rej || wr_refused) begin
      rej_d = 1'b1;
    end
  end

  assign rcnt_d = do_reset ? rcnt_q + 8'h01 : rcnt_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_q   <= BUS_IDLE;
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
      ptr_q   <= PTR_RST;
    end else if (ce) begin
      bus_q   <= bus_d;
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      ptr_q   <= ptr_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      width_q <= WID_RST;
      cqr_q   <= 1'b0;
      arm_q   <= 1'b0;
      wel_q   <= 1'b0;
      vwe_q   <= 1'b0;
    end else if (ce) begin
      width_q <= width_d;
      cqr_q   <= cqr_d;
      arm_q   <= arm_d;
      wel_q   <= wel_d;
      vwe_q   <= vwe_d;
    end
  end

  // Power-up loads both copies from the non-volatile cell
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nv_q   <= nv_sr1_image; // [R7]
      sr1_q  <= nv_sr1_image; // [R7]
      vact_q <= 1'b0;
    end else if (ce) begin
      nv_q   <= nv_d;
      sr1_q  <= sr1_d;
      vact_q <= vact_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rej_q    <= 1'b0;
      rcnt_q   <= RCNT_RST;
      rpulse_q <= 1'b0;
    end else if (ce) begin
      rej_q    <= rej_d;
      rcnt_q   <= rcnt_d;
      rpulse_q <= do_reset;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign sr1_out         = sr1_q;
  assign io_width_out    = width_q;
  assign dev_reset_out   = rpulse_q;

  // Table content is fixed: [R1] [R2] [R3] [R10] [R11] [R12] [R13] [R14]
endmodule
`default_nettype wire

// ==== rtl/sfr_pin_sync.sv ====
// Two-stage synchroniser for the hardware reset pin
`timescale 1ns/10ps
`default_nettype none
module sfr_pin_sync
  import sfr_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic ce,
  sfr_core_if.sync  ps
);
  logic [1:0] stage_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage_q <= SYNC_RST;
    end else if (ce) begin
      stage_q <= {stage_q[0], ps.pin_raw_n};
    end
  end

  assign ps.pin_sync_n = stage_q[1];
endmodule
`default_nettype wire

// ==== rtl/sfr_table_rom.sv ====
// Byte lookup into the parameter table image
`timescale 1ns/10ps
`default_nettype none
module sfr_table_rom
  import sfr_pkg::*;
(
  sfr_core_if.rom lk
);
  wire       in_range;
  wire [7:0] idx;
  wire [6:0] bit_pos;

  assign in_range = (lk.tbl_addr >= TBL_FIRST) && (lk.tbl_addr <= TBL_LAST);
  assign idx      = lk.tbl_addr - TBL_FIRST;
  // Low byte of each dword at the lower address
  assign bit_pos  = {idx[3:0], 3'b000}; // [R15]
  assign lk.tbl_byte = in_range ? TBL_IMAGE[bit_pos +: 8] : TBL_FILL;
endmodule
`default_nettype wire

// ==== shared/sfr_core_if.sv ====
// Links between the core, the table lookup and the pin synchroniser
`timescale 1ns/10ps
`default_nettype none
interface sfr_core_if;
  logic [7:0] tbl_addr;
  logic [7:0] tbl_byte;
  logic       pin_raw_n;
  logic       pin_sync_n;

  modport core (output tbl_addr, input tbl_byte,
                output pin_raw_n, input pin_sync_n);
  modport rom  (input tbl_addr, output tbl_byte);
  modport sync (input pin_raw_n, output pin_sync_n);
endinterface
`default_nettype wire

// ==== shared/sfr_pkg.sv ====
// Constants, table image and register map of the parameter and reset block
// What this block does
// [R1] Bits 31:24 of the last standard parameter dword say that entering four-byte addressing is not supported.
// [R2] Bits 23:14 of that dword say that no way of leaving four-byte addressing is supported.
// [R3] Bits 13:8 of that dword carry the soft reset code: 66h then 99h, leaving continuous quad read first.
// [R4] A software reset happens only after a reset-enable instruction directly followed by a reset instruction.
// [R5] Reset-enable and reset are taken on one, two or four lines, whichever width the current mode uses.
// [R6] A host that may have left continuous quad-address read on must end that mode before the reset pair.
// [R7] At power-up status register 1 takes the value last written into its non-volatile copy.
// [R8] A non-volatile status write needs a preceding write-enable and is refused without it.
// [R9] After the volatile write-enable the next status write loads a volatile copy that overrides until power-off.
// [R10] Bits 6:0 of the last standard dword carry the status write-enable method, and bit 7 reads one.
// [R11] Bits 15:0 of vendor dword 1 carry the maximum supply voltage as volt digits, 2000h.
// [R12] Bits 31:16 of vendor dword 1 carry the minimum supply voltage as volt digits, 1650h.
// [R13] Bit 0 of vendor byte 74h is one, saying a hardware reset pin exists.
// [R14] The next vendor bits say software reset exists with opcode 99h, to be preceded by reset-enable.
// [R15] Table bytes come out in ascending address order, low byte of each dword first.
package sfr_pkg;

  // Last standard parameter dword fields
  localparam logic [7:0]  ENTER4B_CODE = 8'h80; // [R1]
  localparam logic [9:0]  EXIT4B_CODE  = 10'h300; // [R2]
  localparam logic [5:0]  SOFT_RST_CAP = 6'h30; // [R3]
  localparam logic        DW16_BIT7    = 1'b1; // [R10]
  localparam logic [6:0]  SR1_WEN_CODE = 7'h68; // [R10]
  localparam logic [31:0] BFPT_DW16    = {ENTER4B_CODE, EXIT4B_CODE,
                                          SOFT_RST_CAP, DW16_BIT7,
                                          SR1_WEN_CODE};

  // Vendor dword 1: supply range in volt digits
  localparam logic [15:0] VCC_MAX   = 16'h2000; // [R11]
  localparam logic [15:0] VCC_MIN   = 16'h1650; // [R12]
  localparam logic [31:0] VEND_DW1  = {VCC_MIN, VCC_MAX};

  // Vendor dword 2, low half
  localparam logic        CAP_HW_RST  = 1'b1; // [R13]
  localparam logic        CAP_HOLD    = 1'b1;
  localparam logic        CAP_DPD     = 1'b1;
  localparam logic        CAP_SW_RST  = 1'b1; // [R14]
  localparam logic [7:0]  CAP_RST_OPC = 8'h99; // [R14]
  localparam logic        CAP_PGM_SUS = 1'b1;
  localparam logic        CAP_ERS_SUS = 1'b1;
  localparam logic        CAP_UNUSED  = 1'b1;
  localparam logic        CAP_WRAP    = 1'b1;
  localparam logic [15:0] VEND_DW2_LO = {CAP_WRAP, CAP_UNUSED, CAP_ERS_SUS,
                                         CAP_PGM_SUS, CAP_RST_OPC,
                                         CAP_SW_RST, CAP_DPD, CAP_HOLD,
                                         CAP_HW_RST};

  // Table window and fill for bytes outside it
  localparam logic [7:0]  TBL_FIRST = 8'h6c;
  localparam logic [7:0]  TBL_LAST  = 8'h75;
  localparam logic [7:0]  TBL_FILL  = 8'hff;
  localparam logic [79:0] TBL_IMAGE = {VEND_DW2_LO, VEND_DW1, BFPT_DW16};

  // Instruction codes
  localparam logic [7:0] OPC_RST_EN = 8'h66;
  localparam logic [7:0] OPC_RST    = 8'h99;
  localparam logic [7:0] OPC_WREN   = 8'h06;
  localparam logic [7:0] OPC_VWREN  = 8'h50;
  localparam logic [7:0] OPC_WRSR   = 8'h01;
  localparam logic [7:0] OPC_CQR_X  = 8'hff;

  // Line widths
  localparam logic [1:0] WID_1 = 2'h0;
  localparam logic [1:0] WID_2 = 2'h1;
  localparam logic [1:0] WID_4 = 2'h2;

  // Register byte offsets
  localparam int         ADDR_W       = 5;
  localparam logic [4:0] REG_TBL_ADDR = 5'h00;
  localparam logic [4:0] REG_TBL_DATA = 5'h04;
  localparam logic [4:0] REG_CMD      = 5'h08;
  localparam logic [4:0] REG_MODE     = 5'h0c;
  localparam logic [4:0] REG_STAT     = 5'h10;

  // Field positions
  localparam int CMD_OPC_LSB  = 0;
  localparam int CMD_WID_LSB  = 8;
  localparam int CMD_DAT_LSB  = 16;
  localparam int MODE_WID_LSB = 0;
  localparam int MODE_CQR_BIT = 2;
  localparam int ST_REJ_BIT   = 28;

  // Values after reset
  localparam logic [1:0] WID_RST   = WID_1;
  localparam logic [7:0] PTR_RST   = 8'h00;
  localparam logic [7:0] RCNT_RST  = 8'h00;
  localparam logic [1:0] SYNC_RST  = 2'h3;

  typedef enum logic {BUS_IDLE, BUS_ACK} sfr_bus_t;

endpackage

// ==== tb/sfr_core_assertions.sv ====
// Port checker for the parameter and reset block
`timescale 1ns/10ps
`default_nettype none
module sfr_chk (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        hw_reset_n_pin,
  input wire logic [7:0]  nv_sr1_image,
  input wire logic [7:0]  sr1_out,
  input wire logic [1:0]  io_width_out,
  input wire logic        dev_reset_out
);
  wire logic acc;
  assign acc = avs_write && !avs_waitrequest;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_wait_one_cycle: assert property ($fell(avs_waitrequest) |=>
    avs_waitrequest) else $error("waitrequest low too long");
  a_wait_has_cause: assert property (!avs_waitrequest |->
    $past(avs_read || avs_write)) else $error("answer without request");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address > 5'h10 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_powerup_sr1: assert property ($fell(reset) |->
    sr1_out == nv_sr1_image && io_width_out == 2'h0 && !dev_reset_out)
    else $error("bad values after reset");
  a_pin_resets: assert property (!hw_reset_n_pin [*4] |=>
    dev_reset_out) else $error("pin low gave no reset");
  a_reset_pair_only: assert property ($rose(dev_reset_out) &&
    $past(hw_reset_n_pin, 2) && $past(hw_reset_n_pin, 3) |->
    $past(acc && avs_address == 5'h08 && avs_writedata[7:0] == 8'h99))
    else $error("reset without reset instruction");
  a_mode_width: assert property (acc && avs_address == 5'h0c &&
    avs_byteenable[0] |-> ##[1:2] io_width_out == $past(avs_writedata[1:0]))
    else $error("width not taken");
  a_sr1_cause: assert property ($changed(sr1_out) |->
    $past(acc && avs_address == 5'h08 && avs_writedata[7:0] == 8'h01))
    else $error("status changed without write");
  c_reset: cover property ($rose(dev_reset_out));
  c_sr1: cover property ($changed(sr1_out));
  c_unmapped: cover property (avs_read && !avs_waitrequest &&
    avs_address > 5'h10);
endmodule
bind sfr_core sfr_chk sfr_chk_i (.clk_sys(clk_sys), .reset(reset), .ce(ce),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .hw_reset_n_pin(hw_reset_n_pin), .nv_sr1_image(nv_sr1_image),
  .sr1_out(sr1_out), .io_width_out(io_width_out),
  .dev_reset_out(dev_reset_out));
`default_nettype wire

// ==== tb/sfr_host.sv ====
// Host controller model driving the register bus
`timescale 1ns/10ps
`default_nettype none
module sfr_host
  import sfr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output var  logic [4:0]  avs_address,
  output var  logic        avs_read,
  output var  logic        avs_write,
  output var  logic [31:0] avs_writedata,
  output var  logic [3:0]  avs_byteenable,
  output var  logic        tmo
);
  logic [31:0] r;
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    tmo = 1'b0;
  end
  task automatic xfer(input logic wr, input logic [4:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    rd = avs_readdata;
    if (n >= 64) tmo <= 1'b1;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released data does not keep its last value
    avs_writedata <= ~wd;
    @(posedge clk_sys);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [1:0] w,
                     input logic [7:0] d);
    xfer(1'b1, REG_CMD, {8'h00, d, 6'h00, w, op}, r);
  endtask
  task automatic reset_pair(input logic [1:0] w);
    cmd(OPC_RST_EN, w, 8'h00);
    cmd(OPC_RST, w, 8'h00);
  endtask
  task automatic quad_exit;
    cmd(OPC_CQR_X, WID_4, 8'h00);
  endtask
  task automatic nv_write(input logic [7:0] d);
    cmd(OPC_WREN, WID_1, 8'h00);
    cmd(OPC_WRSR, WID_1, d);
  endtask
endmodule
`default_nettype wire

// ==== tb/test_sfdp_reset_status_capability.sv ====
// Testbench for the parameter table and reset/status engine
`timescale 1ns/10ps
`default_nettype none
module test_sfdp_reset_status_capability;
  import sfr_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        pin_n = 1'b1;
  logic [7:0]  nv = 8'h3c;
  logic [4:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wd;
  logic [3:0]  be;
  logic [31:0] rdat;
  logic        wait_q;
  logic        tmo;
  logic [7:0]  sr1;
  logic [1:0]  wid;
  logic        dev_rst;
  logic [31:0] d;
  logic [79:0] tbl;
  int          n_errors = 0;
  int          checked = 0;
  int          n_rst = 0;
  int          k;
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (dev_rst === 1'b1) n_rst <= n_rst + 1;
  sfr_core sfr_core_i (.clk_sys(clk_sys), .reset(reset), .ce(1'b1),
    .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_q), .hw_reset_n_pin(pin_n),
    .nv_sr1_image(nv), .sr1_out(sr1), .io_width_out(wid),
    .dev_reset_out(dev_rst));
  sfr_host sfr_host_i (.clk_sys(clk_sys), .avs_readdata(rdat),
    .avs_waitrequest(wait_q), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .tmo(tmo));
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out;
    $display("Mismatches %0d of %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys);
  endtask
  always @(posedge tmo) begin
    n_errors++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk("sr1 power-up", sr1, nv);
    sfr_host_i.xfer(1'b1, REG_TBL_ADDR, 32'h6c, d);
    for (int i = 0; i < 10; i++) begin
      sfr_host_i.xfer(1'b0, REG_TBL_DATA, 32'h0, d);
      tbl[8*i +: 8] = d[7:0];
    end
    chk("enter4b", tbl[31:24], 32'h80);
    chk("exit4b", tbl[23:14], 32'h300);
    chk("soft reset cap", tbl[13:8], 32'h30);
    chk("sr1 method", tbl[7:0], 32'he8);
    chk("vcc max", tbl[47:32], 32'h2000);
    chk("vcc min", tbl[63:48], 32'h1650);
    chk("hw pin cap", tbl[64], 32'h1);
    chk("sw reset cap", tbl[75:67], 32'h133);
    chk("last dword", tbl[31:0], 32'h80c030e8);
    sfr_host_i.xfer(1'b0, 5'h14, 32'h0, d);
    chk("unmapped", d, 32'h0);
    for (int w = 0; w < 3; w++) begin
      sfr_host_i.xfer(1'b1, REG_MODE, w, d);
      chk("width", wid, w);
      k = n_rst;
      sfr_host_i.reset_pair(2'(w));
      settle();
      chk("soft reset", n_rst - k, 1);
      chk("width cleared", wid, 0);
    end
    k = n_rst;
    sfr_host_i.cmd(OPC_RST, WID_1, 8'h00);
    sfr_host_i.cmd(OPC_RST_EN, WID_1, 8'h00);
    sfr_host_i.cmd(OPC_WREN, WID_1, 8'h00);
    sfr_host_i.cmd(OPC_RST, WID_1, 8'h00);
    sfr_host_i.reset_pair(WID_2);
    settle();
    chk("broken pair", n_rst - k, 0);
    sfr_host_i.xfer(1'b1, REG_MODE, 32'h6, d);
    sfr_host_i.reset_pair(WID_4);
    settle();
    chk("quad blocks reset", n_rst - k, 0);
    sfr_host_i.quad_exit();
    sfr_host_i.reset_pair(WID_4);
    settle();
    chk("reset after exit", n_rst - k, 1);
    // Clear the sticky flag so only the refused status write can set it
    sfr_host_i.xfer(1'b1, REG_STAT, 32'h1000_0000, d);
    sfr_host_i.xfer(1'b0, REG_STAT, 32'h0, d);
    chk("refused flag clear", d[28], 0);
    sfr_host_i.cmd(OPC_WRSR, WID_1, 8'ha5);
    chk("sr1 refused", sr1, nv);
    sfr_host_i.xfer(1'b0, REG_STAT, 32'h0, d);
    chk("refused flag", d[28], 1);
    sfr_host_i.nv_write(8'ha5);
    chk("sr1 nv write", sr1, 8'ha5);
    sfr_host_i.cmd(OPC_VWREN, WID_1, 8'h00);
    sfr_host_i.cmd(OPC_WRSR, WID_1, 8'h5a);
    chk("sr1 volatile", sr1, 8'h5a);
    sfr_host_i.nv_write(8'h11);
    chk("volatile wins", sr1, 8'h5a);
    sfr_host_i.xfer(1'b0, REG_STAT, 32'h0, d);
    chk("nv behind volatile", d[15:8], 8'h11);
    sfr_host_i.xfer(1'b1, REG_MODE, 32'h2, d);
    k = n_rst;
    pin_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    pin_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("pin reset", n_rst > k, 1);
    chk("pin width", wid, 0);
    reset <= 1'b1;
    nv <= 8'h77;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk("sr1 reload", sr1, 8'h77);
    close_out();
  end
endmodule
`default_nettype wire
